// ---- src/ashp_device.sv ----
/*
  Device end of the strobe-style host bus port with its register file.
  Assumes strobe pins synchronous to clk_i and a pull-up on the irq wire.
*/
`timescale 1ns/100ps
module ashp_device
  import ashp_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  ashp_if.device_mp       bus,
  input  wire logic       bus_style_i,
  input  wire logic [7:0] irq_event_i,
  input  wire logic       chan_a_serial_in_i,
  input  wire logic       chan_b_serial_in_i,
  output logic            chan_a_serial_out_o,
  output logic            chan_b_serial_out_o,
  output logic [7:0]      gen_out_o,
  output logic            timer_run_o,
  output logic [1:0]      chan_active_o,
  output logic [1:0]      mode_reg_pointer_o
);
  // ---------------------------------------------------------------
  // Strobe edges
  // ---------------------------------------------------------------
  logic wr_fall;
  logic wr_rise;
  logic rd_fall;
  logic rd_rise;

  ashp_edge u_wr_edge (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .strobe_n_i (bus.write_strobe_n),
    .fall_o     (wr_fall),
    .rise_o     (wr_rise)
  );
  ashp_edge u_rd_edge (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .strobe_n_i (bus.read_strobe_n),
    .fall_o     (rd_fall),
    .rise_o     (rd_rise)
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0] stat_a_q, stat_a_d;
  logic [7:0] stat_b_q, stat_b_d;
  logic [7:0] irq_mask_reg_q, irq_mask_reg_d;
  logic [7:0] irq_status_reg_q, irq_status_reg_d;
  logic [7:0] out_port_value_reg_q, out_port_value_reg_d;
  logic [7:0] out_port_config_reg_q, out_port_config_reg_d;
  logic [7:0] mode_a_q [2], mode_a_d [2];
  logic [7:0] mode_b_q [2], mode_b_d [2];
  logic [1:0] mptr_q, mptr_d;
  logic [7:0] shift_a_q, shift_a_d;
  logic [7:0] shift_b_q, shift_b_d;
  logic [7:0] rx_a_q, rx_a_d;
  logic [7:0] rx_b_q, rx_b_d;
  logic [7:0] rdata_q, rdata_d;
  logic       oe_q, oe_d;
  logic       irq_oe_q, irq_oe_d;
  logic       wr_pend_q, wr_pend_d;
  logic       selected;
  logic       style_ok;

  // Only the strobe style is built; the other bus style ignores the strobes, but the irq output still follows status and mask.
  assign style_ok = bus_style_i;
  assign selected = style_ok & ~bus.chip_select_n;

  function automatic logic [7:0] lsb_shift(input logic [7:0] v, input logic b);
    lsb_shift = {b, v[7:1]};
  endfunction : lsb_shift

  function automatic logic [7:0] reg_read(input logic [3:0] a);
    case (a)
      REG_MODE_A:   reg_read = mode_a_q[mptr_q[0]];
      REG_STAT_A:   reg_read = stat_a_q;
      REG_DATA_A:   reg_read = rx_a_q;
      REG_IRQ_STAT: reg_read = irq_status_reg_q;
      REG_IRQ_MASK: reg_read = irq_mask_reg_q;
      REG_MODE_B:   reg_read = mode_b_q[mptr_q[1]];
      REG_STAT_B:   reg_read = stat_b_q;
      REG_DATA_B:   reg_read = rx_b_q;
      REG_OP_CFG:   reg_read = out_port_config_reg_q;
      REG_OP_VAL:   reg_read = out_port_value_reg_q;
      default:      reg_read = REG_RST;
    endcase
  endfunction : reg_read

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    stat_a_d              = stat_a_q;
    stat_b_d              = stat_b_q;
    irq_mask_reg_d        = irq_mask_reg_q;
    out_port_value_reg_d  = out_port_value_reg_q;
    out_port_config_reg_d = out_port_config_reg_q;
    mode_a_d              = mode_a_q;
    mode_b_d              = mode_b_q;
    mptr_d                = mptr_q;
    shift_a_d             = shift_a_q;
    shift_b_d             = shift_b_q;
    rx_a_d                = lsb_shift(rx_a_q, chan_a_serial_in_i);
    rx_b_d                = lsb_shift(rx_b_q, chan_b_serial_in_i);
    rdata_d               = rdata_q;
    // Hardware events set status bits; the set wins over a same-cycle write.
    irq_status_reg_d      = irq_status_reg_q | irq_event_i;
    wr_pend_d             = wr_pend_q;
    // Data drive is registered: it starts and ends one cycle after select and read strobe are both low.
    oe_d = selected & ~bus.read_strobe_n & ~rd_rise;
    if (selected && rd_fall)
    begin
      rdata_d = reg_read(bus.reg_addr);
      if (bus.reg_addr == REG_MODE_A)
        mptr_d[0] = 1'b1;
      if (bus.reg_addr == REG_MODE_B)
        mptr_d[1] = 1'b1;
    end
    if (selected && !bus.write_strobe_n)
      wr_pend_d = 1'b1;
    if (wr_rise && wr_pend_q)
    begin
      wr_pend_d = 1'b0;
      case (bus.reg_addr)
        REG_MODE_A:
        begin
          mode_a_d[mptr_q[0]] = bus.host_bus_in;
          mptr_d[0]           = 1'b1;
        end
        REG_MODE_B:
        begin
          mode_b_d[mptr_q[1]] = bus.host_bus_in;
          mptr_d[1]           = 1'b1;
        end
        REG_DATA_A:   shift_a_d = bus.host_bus_in;
        REG_DATA_B:   shift_b_d = bus.host_bus_in;
        REG_IRQ_MASK: irq_mask_reg_d = bus.host_bus_in;
        REG_IRQ_STAT: irq_status_reg_d = (irq_status_reg_q & ~bus.host_bus_in) | irq_event_i;
        REG_OP_CFG:   out_port_config_reg_d = bus.host_bus_in;
        REG_OP_VAL:   out_port_value_reg_d = bus.host_bus_in;
        default:      ;
      endcase
    end
    else
    begin
      // Transmit LSB first; an emptied shifter idles at mark.
      shift_a_d = {1'b0, shift_a_q[7:1]};
      shift_b_d = {1'b0, shift_b_q[7:1]};
    end
    stat_a_d[STAT_TX_IDLE] = (shift_a_d == REG_RST);
    stat_b_d[STAT_TX_IDLE] = (shift_b_d == REG_RST);
    irq_oe_d = |(irq_status_reg_d & irq_mask_reg_d);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stat_a_q              <= REG_RST;
      stat_b_q              <= REG_RST;
      irq_mask_reg_q        <= REG_RST;
      irq_status_reg_q      <= REG_RST;
      out_port_value_reg_q  <= REG_RST;
      out_port_config_reg_q <= REG_RST;
      mode_a_q              <= '{REG_RST, REG_RST};
      mode_b_q              <= '{REG_RST, REG_RST};
      mptr_q                <= {PTR_FIRST, PTR_FIRST};
      shift_a_q             <= REG_RST;
      shift_b_q             <= REG_RST;
      rx_a_q                <= REG_RST;
      rx_b_q                <= REG_RST;
      rdata_q               <= REG_RST;
      oe_q                  <= 1'b0;
      irq_oe_q              <= 1'b0;
      wr_pend_q             <= 1'b0;
      chan_a_serial_out_o   <= LINE_MARK;
      chan_b_serial_out_o   <= LINE_MARK;
      gen_out_o             <= PORT_ALL_HI;
      timer_run_o           <= 1'b0;
      chan_active_o         <= 2'b00;
      mode_reg_pointer_o    <= {PTR_FIRST, PTR_FIRST};
    end
    else
    begin
      stat_a_q              <= stat_a_d;
      stat_b_q              <= stat_b_d;
      irq_mask_reg_q        <= irq_mask_reg_d;
      irq_status_reg_q      <= irq_status_reg_d;
      out_port_value_reg_q  <= out_port_value_reg_d;
      out_port_config_reg_q <= out_port_config_reg_d;
      mode_a_q              <= mode_a_d;
      mode_b_q              <= mode_b_d;
      mptr_q                <= mptr_d;
      shift_a_q             <= shift_a_d;
      shift_b_q             <= shift_b_d;
      rx_a_q                <= rx_a_d;
      rx_b_q                <= rx_b_d;
      rdata_q               <= rdata_d;
      oe_q                  <= oe_d;
      irq_oe_q              <= irq_oe_d;
      wr_pend_q             <= wr_pend_d;
      chan_a_serial_out_o   <= shift_a_d[0] | stat_a_d[STAT_TX_IDLE];
      chan_b_serial_out_o   <= shift_b_d[0] | stat_b_d[STAT_TX_IDLE];
      // Output pins are the inverse of the port value register.
      gen_out_o             <= ~out_port_value_reg_d;
      timer_run_o           <= |out_port_config_reg_d;
      chan_active_o         <= {~stat_b_d[STAT_TX_IDLE], ~stat_a_d[STAT_TX_IDLE]};
      mode_reg_pointer_o    <= mptr_d;
    end
  end

  assign bus.host_bus_dev     = rdata_q;
  assign bus.host_bus_dev_oe  = oe_q;
  assign bus.irq_request_n_oe = irq_oe_q;
endmodule : ashp_device

// ---- src/ashp_pkg.sv ----
/*
  Constants shared by both ends of the strobe-style host bus port.
  Assumes one 250 MHz clock and synchronous pins on both ends.
*/
package ashp_pkg;
  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned NUM_REG = 16;
  localparam int unsigned NUM_IRQ = 8;
  // ---------------------------------------------------------------
  // Register indices inside the port
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_MODE_A   = 4'h0;
  localparam logic [3:0] REG_STAT_A   = 4'h1;
  localparam logic [3:0] REG_DATA_A   = 4'h3;
  localparam logic [3:0] REG_IRQ_STAT = 4'h5;
  localparam logic [3:0] REG_IRQ_MASK = 4'h6;
  localparam logic [3:0] REG_MODE_B   = 4'h8;
  localparam logic [3:0] REG_STAT_B   = 4'h9;
  localparam logic [3:0] REG_DATA_B   = 4'hB;
  localparam logic [3:0] REG_OP_CFG   = 4'hD;
  localparam logic [3:0] REG_OP_VAL   = 4'hE;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_RST      = 8'h00;
  localparam logic [7:0] PORT_ALL_HI  = 8'hFF;
  localparam logic       LINE_MARK    = 1'b1;
  localparam logic       PTR_FIRST    = 1'b0;
  // Status bit 2 of a channel status register: transmitter idle.
  localparam int unsigned STAT_TX_IDLE = 2;
  // ---------------------------------------------------------------
  // Host controller Wishbone registers
  // ---------------------------------------------------------------
  localparam logic [3:0] WB_CMD   = 4'h0;
  localparam logic [3:0] WB_WDATA = 4'h4;
  localparam logic [3:0] WB_RDATA = 4'h8;
  localparam logic [3:0] WB_STAT  = 4'hC;
  localparam int unsigned CMD_ADDR_LSB = 0;
  localparam int unsigned CMD_WRITE    = 4;
  localparam int unsigned CMD_START    = 8;
  // Strobe low time and gap, with the clock period, in ns; STROBE_CYC gives them in cycles.
  localparam int unsigned STROBE_NS     = 16;
  localparam int unsigned CLK_NS        = 4;
  localparam logic [3:0]  STROBE_CYC    = 4'(STROBE_NS / CLK_NS);
endpackage : ashp_pkg

// ---- src/ashp_if.sv ----
/*
  Pin bundle joining the device end and the host end.
  Assumes the bench resolves the shared data wire from both enables.
*/
`timescale 1ns/100ps
interface ashp_if;
  logic       chip_select_n;
  logic       write_strobe_n;
  logic       read_strobe_n;
  logic [3:0] reg_addr;
  logic [7:0] host_bus_host;
  logic       host_bus_host_oe;
  logic [7:0] host_bus_dev;
  logic       host_bus_dev_oe;
  logic [7:0] host_bus_in;
  logic       irq_request_n_oe;
  logic       irq_request_n_in;

  modport device_mp (
    input  chip_select_n, write_strobe_n, read_strobe_n, reg_addr, host_bus_in,
    output host_bus_dev, host_bus_dev_oe, irq_request_n_oe
  );
  modport host_mp (
    output chip_select_n, write_strobe_n, read_strobe_n, reg_addr,
    output host_bus_host, host_bus_host_oe,
    input  host_bus_in, irq_request_n_in
  );
endinterface : ashp_if

// ---- src/ashp_edge.sv ----
/*
  Strobe edge finder for the device end.
  Assumes its input is already synchronous to clk_i.
*/
`timescale 1ns/100ps
module ashp_edge
  import ashp_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic strobe_n_i,
  output logic      fall_o,
  output logic      rise_o
);
  logic prev_q;
  logic prev_d;

  always_comb
  begin
    prev_d = strobe_n_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prev_q <= 1'b1;
    else
      prev_q <= prev_d;
  end

  assign fall_o = prev_q & ~strobe_n_i;
  assign rise_o = ~prev_q & strobe_n_i;
endmodule : ashp_edge

// ---- src/ashp_host.sv ----
/*
  Host end: a Wishbone slave that runs one strobe access per command.
  Assumes classic Wishbone single cycles on clk_i.
*/
`timescale 1ns/100ps
module ashp_host
  import ashp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  ashp_if.host_mp          bus,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);
  typedef enum {ST_IDLE, ST_STROBE, ST_GAP} ashp_state_e;
  ashp_state_e state_q, state_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [3:0]  addr_q, addr_d;
  logic [7:0]  wdata_q, wdata_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        write_q, write_d;
  logic        ack_d;
  logic [31:0] dat_d;
  logic        req;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    write_d = write_q;
    ack_d   = 1'b0;
    dat_d   = 32'h0000_0000;
    if (req)
    begin
      ack_d = 1'b1;
      case (wb_adr_i)
        WB_CMD:
        begin
          if (wb_we_i && wb_sel_i[1] && wb_dat_i[CMD_START] && state_q == ST_IDLE)
          begin
            addr_d  = wb_dat_i[CMD_ADDR_LSB +: ADDR_W];
            write_d = wb_dat_i[CMD_WRITE];
            state_d = ST_STROBE;
            cnt_d   = STROBE_CYC;
          end
        end
        WB_WDATA: if (wb_we_i && wb_sel_i[0]) wdata_d = wb_dat_i[7:0];
        WB_RDATA: dat_d = {24'h00_0000, rdata_q};
        WB_STAT:  dat_d = {24'h00_0000, 6'h00, ~bus.irq_request_n_in, state_q != ST_IDLE};
        default:  dat_d = 32'h0000_0000;
      endcase
    end
    case (state_q)
      ST_IDLE: ;
      ST_STROBE:
      begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1)
        begin
          if (!write_q)
            rdata_d = bus.host_bus_in;
          state_d = ST_GAP;
          cnt_d   = STROBE_CYC;
        end
      end
      ST_GAP:
      begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1)
          state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q  <= ST_IDLE;
      cnt_q    <= 4'h0;
      addr_q   <= 4'h0;
      wdata_q  <= 8'h00;
      rdata_q  <= 8'h00;
      write_q  <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      addr_q   <= addr_d;
      wdata_q  <= wdata_d;
      rdata_q  <= rdata_d;
      write_q  <= write_d;
      wb_ack_o <= ack_d;
      wb_dat_o <= dat_d;
    end
  end

  // Select and address stay stable across the whole strobe and gap.
  assign bus.chip_select_n    = (state_q == ST_IDLE);
  assign bus.reg_addr         = addr_q;
  assign bus.write_strobe_n   = ~(state_q == ST_STROBE && write_q);
  assign bus.read_strobe_n    = ~(state_q == ST_STROBE && !write_q);
  assign bus.host_bus_host    = wdata_q;
  assign bus.host_bus_host_oe = (state_q != ST_IDLE) && write_q;
endmodule : ashp_host

// ---- dv/ashp_monitor.sv ----
/*
  Concurrent checks on the strobe link between the host end and the device end.
  Assumes it sits beside the link, on the bench clock and synchronous reset.
*/
`timescale 1ns/100ps
module ashp_monitor
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       chip_select_n,
  input  wire logic       write_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic [3:0] reg_addr,
  input  wire logic       host_bus_host_oe,
  input  wire logic [7:0] host_bus_dev,
  input  wire logic       host_bus_dev_oe
);
  // ---------------------------------------------------------------
  // Link properties
  // ---------------------------------------------------------------
  property p_cs_release;
    @(posedge clk_i) disable iff (rst_i)
    chip_select_n && $past(chip_select_n) |-> !host_bus_dev_oe;
  endproperty
  a_cs_release: assert property (p_cs_release)
    else $error("device drove bus while deselected");
  property p_read_answer;
    @(posedge clk_i) disable iff (rst_i)
    $fell(read_strobe_n) && !chip_select_n |=> host_bus_dev_oe;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read strobe got no bus drive");
  property p_drive_cause;
    @(posedge clk_i) disable iff (rst_i)
    host_bus_dev_oe |-> !$past(read_strobe_n) && !$past(chip_select_n);
  endproperty
  a_drive_cause: assert property (p_drive_cause)
    else $error("device drove bus without a read");
  property p_no_fight;
    @(posedge clk_i) disable iff (rst_i)
    !(host_bus_dev_oe && host_bus_host_oe);
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("both ends drive the data bus");
  property p_no_overlap;
    @(posedge clk_i) disable iff (rst_i)
    !chip_select_n |-> read_strobe_n || write_strobe_n;
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("read and write strobes overlap");
  property p_addr_stable;
    @(posedge clk_i) disable iff (rst_i)
    !write_strobe_n || !read_strobe_n |=> (write_strobe_n && read_strobe_n) || $stable(reg_addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("address moved inside a strobe");
  property p_write_len;
    @(posedge clk_i) disable iff (rst_i)
    $fell(write_strobe_n) |-> !write_strobe_n[*4] ##1 write_strobe_n;
  endproperty
  a_write_len: assert property (p_write_len)
    else $error("write strobe length wrong");
  property p_write_data;
    @(posedge clk_i) disable iff (rst_i)
    !write_strobe_n |-> host_bus_host_oe && !chip_select_n;
  endproperty
  a_write_data: assert property (p_write_data)
    else $error("write strobe without data or select");
  property p_read_stable;
    @(posedge clk_i) disable iff (rst_i)
    host_bus_dev_oe && $past(host_bus_dev_oe) |-> $stable(host_bus_dev);
  endproperty
  a_read_stable: assert property (p_read_stable)
    else $error("read data changed while driven");
endmodule : ashp_monitor

// ---- dv/tb_async_strobe_host_bus_port.sv ----
/*
  Self-checking bench: host end and device end joined over the link.
  Assumes the host end runs one strobe access per command and reports busy.
*/
`timescale 1ns/100ps
module tb_async_strobe_host_bus_port;
  import ashp_pkg::*;
  logic        clk_i      = 1'b0;
  logic        rst_i      = 1'b1;
  logic        bus_style  = 1'b1;
  logic [7:0]  irq_event  = 8'h00;
  logic [3:0]  wb_adr     = 4'h0;
  logic [31:0] wb_dat     = 32'h0;
  logic        wb_we      = 1'b0;
  logic [3:0]  wb_sel     = 4'h0;
  logic        wb_cyc     = 1'b0;
  logic        wb_stb     = 1'b0;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        ser_a, ser_b, timer_run;
  logic [7:0]  gen_out;
  logic [1:0]  chan_active, mr_ptr;
  logic [7:0]  idle_pat_q = 8'h00;
  logic        ser_in_a   = 1'b1;
  logic        ser_in_b   = 1'b1;
  int          num_errors = 0;
  int          samples_checked = 0;

  always #2 clk_i = ~clk_i;
  // A released data wire shows a moving pattern so a stale value never reads as valid.
  always @(posedge clk_i) idle_pat_q <= idle_pat_q + 8'h01;

  ashp_if i_ashp_if ();
  assign i_ashp_if.host_bus_in = i_ashp_if.host_bus_dev_oe ? i_ashp_if.host_bus_dev :
                                 i_ashp_if.host_bus_host_oe ? i_ashp_if.host_bus_host : idle_pat_q;
  assign i_ashp_if.irq_request_n_in = ~i_ashp_if.irq_request_n_oe;

  ashp_device i_ashp_device (.clk_i(clk_i), .rst_i(rst_i), .bus(i_ashp_if.device_mp),
    .bus_style_i(bus_style), .irq_event_i(irq_event), .chan_a_serial_in_i(ser_in_a),
    .chan_b_serial_in_i(ser_in_b), .chan_a_serial_out_o(ser_a), .chan_b_serial_out_o(ser_b),
    .gen_out_o(gen_out), .timer_run_o(timer_run), .chan_active_o(chan_active),
    .mode_reg_pointer_o(mr_ptr));
  ashp_host i_ashp_host (.clk_i(clk_i), .rst_i(rst_i), .bus(i_ashp_if.host_mp),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_we_i(wb_we), .wb_sel_i(wb_sel),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
  ashp_monitor i_ashp_monitor (.clk_i(clk_i), .rst_i(rst_i),
    .chip_select_n(i_ashp_if.chip_select_n), .write_strobe_n(i_ashp_if.write_strobe_n),
    .read_strobe_n(i_ashp_if.read_strobe_n), .reg_addr(i_ashp_if.reg_addr),
    .host_bus_host_oe(i_ashp_if.host_bus_host_oe), .host_bus_dev(i_ashp_if.host_bus_dev),
    .host_bus_dev_oe(i_ashp_if.host_bus_dev_oe));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_byte

  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic wb_xfer(input logic [3:0] adr, input logic we, input logic [31:0] dat,
                         input logic [3:0] sel, output logic [31:0] rd);
    @(posedge clk_i);
    wb_adr <= adr;
    wb_we  <= we;
    wb_dat <= dat;
    wb_sel <= sel;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    do
    begin
      @(posedge clk_i);
    end
    while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask : wb_xfer

  task automatic dev_acc(input logic [3:0] addr, input logic we, input logic [7:0] data,
                         output logic [7:0] rd);
    logic [31:0] tmp;
    int          n;
    n = 0;
    wb_xfer(WB_WDATA, 1'b1, {24'h0, data}, 4'h1, tmp);
    wb_xfer(WB_CMD, 1'b1, {23'h0, 1'b1, 3'h0, we, addr}, 4'h3, tmp);
    do
    begin
      wb_xfer(WB_STAT, 1'b0, 32'h0, 4'hF, tmp);
      n++;
    end
    while (tmp[0] !== 1'b0 && n < 50);
    if (n >= 50)
      num_errors++;
    wb_xfer(WB_RDATA, 1'b0, 32'h0, 4'hF, tmp);
    rd = tmp[7:0];
  endtask : dev_acc

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic do_reset;
    logic [7:0] rd;
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    check_byte("gen_out", 8'hFF, gen_out);
    check_byte("serial outs", 8'h03, {6'h00, ser_a, ser_b});
    check_byte("timer and chans", 8'h00, {5'h00, timer_run, chan_active});
    check_byte("mode pointer", 8'h00, {6'h00, mr_ptr});
    check_byte("irq line", 8'h01, {7'h00, i_ashp_if.irq_request_n_in});
    rst_i <= 1'b0;
    dev_acc(REG_IRQ_MASK, 1'b0, 8'h00, rd);
    check_byte("mask after reset", REG_RST, rd);
    dev_acc(REG_OP_CFG, 1'b0, 8'h00, rd);
    check_byte("port cfg after reset", REG_RST, rd);
    dev_acc(REG_IRQ_STAT, 1'b0, 8'h00, rd);
    check_byte("irq stat after reset", REG_RST, rd);
  endtask : do_reset

  task automatic t_write_read;
    logic [3:0] adr [3] = '{REG_IRQ_MASK, REG_OP_VAL, REG_OP_CFG};
    logic [7:0] val [3] = '{8'hA5, 8'h3C, 8'h01};
    logic [7:0] rd;
    foreach (adr[i]) dev_acc(adr[i], 1'b1, val[i], rd);
    foreach (adr[i])
    begin
      dev_acc(adr[i], 1'b0, 8'h00, rd);
      check_byte("read back", val[i], rd);
    end
    check_byte("gen_out", 8'hC3, gen_out);
    check_byte("timer run", 8'h01, {7'h00, timer_run});
  endtask : t_write_read

  task automatic t_irq;
    logic [7:0]  rd;
    logic [31:0] stat;
    int          n;
    n = 0;
    dev_acc(REG_IRQ_MASK, 1'b1, 8'h01, rd);
    irq_event <= 8'h02;
    repeat (6) @(posedge clk_i);
    check_byte("masked irq", 8'h01, {7'h00, i_ashp_if.irq_request_n_in});
    irq_event <= 8'h01;
    while (i_ashp_if.irq_request_n_in !== 1'b0 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    irq_event <= 8'h00;
    check_byte("enabled irq", 8'h00, {7'h00, i_ashp_if.irq_request_n_in});
    // The status bit is sticky, so the host must still report the request.
    wb_xfer(WB_STAT, 1'b0, 32'h0000_0000, 4'hF, stat);
    check_byte("wb irq pending", 8'h01, {7'h00, stat[1]});
    dev_acc(REG_IRQ_STAT, 1'b0, 8'h00, rd);
    check_byte("irq stat", 8'h03, rd);
    dev_acc(REG_IRQ_STAT, 1'b1, 8'hFF, rd);
    repeat (4) @(posedge clk_i);
    check_byte("cleared irq", 8'h01, {7'h00, i_ashp_if.irq_request_n_in});
  endtask : t_irq

  task automatic t_pointer_style;
    logic [7:0] rd;
    dev_acc(REG_MODE_A, 1'b0, 8'h00, rd);
    check_byte("pointer after read A", 8'h01, {6'h00, mr_ptr});
    dev_acc(REG_MODE_B, 1'b0, 8'h00, rd);
    check_byte("pointer after read B", 8'h03, {6'h00, mr_ptr});
    do_reset();
    // With the style pin low the device must ignore the write entirely.
    bus_style <= 1'b0;
    dev_acc(REG_IRQ_MASK, 1'b1, 8'h3C, rd);
    bus_style <= 1'b1;
    dev_acc(REG_IRQ_MASK, 1'b0, 8'h00, rd);
    check_byte("write ignored", REG_RST, rd);
  endtask : t_pointer_style

  task automatic t_serial;
    logic [7:0] rd;
    // Receivers shift every clock, so the input is held for a full byte first.
    ser_in_b <= 1'b0;
    repeat (8) @(posedge clk_i);
    dev_acc(REG_DATA_B, 1'b0, 8'h00, rd);
    check_byte("rx B", 8'h00, rd);
    dev_acc(REG_DATA_A, 1'b0, 8'h00, rd);
    check_byte("rx A", 8'hFF, rd);
    dev_acc(REG_DATA_A, 1'b1, 8'h32, rd);
    repeat (8) @(posedge clk_i);
    check_byte("tx back at mark", 8'h03, {6'h00, ser_a, ser_b});
    check_byte("tx inactive", 8'h00, {6'h00, chan_active});
    dev_acc(REG_STAT_A, 1'b0, 8'h00, rd);
    check_byte("stat A idle", 8'(1 << STAT_TX_IDLE), rd);
  endtask : t_serial

  initial
  begin
    do_reset();
    t_write_read();
    t_irq();
    t_pointer_style();
    t_serial();
    report_and_stop();
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    report_and_stop();
  end
endmodule : tb_async_strobe_host_bus_port
